// File: common/isr_defines.vh
// Register map, field positions and reset values of the I2C register target
`ifndef ISR_DEFINES_VH
`define ISR_DEFINES_VH
`define ISR_REG_DATA 8'h80
`define ISR_REG_DLEN 8'h81
`define ISR_REG_STATE 8'h82
`define ISR_REG_ADDR 8'h83
`define ISR_REG_MAXCLK 8'h84
`define ISR_REG_GUARD 8'h85
`define ISR_REG_TMO 8'h86
`define ISR_REG_RESTART 8'h88
`define ISR_REG_SPEED 8'h89
`define ISR_DLEN_MIN 16'h0010
`define ISR_FRAME_OVH 16'h0005
`define ISR_ADDR_RESET 7'h30
`define ISR_SPEED_RESET 3'h3
`define ISR_SPEED_SM 3'h1
`define ISR_SPEED_FM 3'h2
`define ISR_SPEED_SMFM 3'h3
`define ISR_SPEED_FMP 3'h4
`define ISR_PERSIST_BIT 15
`define ISR_CLK_MIN_KHZ 32'h0000_0032
`define ISR_CLK_FM_KHZ 32'h0000_0190
`define ISR_CLK_FMP_KHZ 32'h0000_03E8
`define ISR_UNSUPPORTED 32'h0FFF_FFFF
`define ISR_SPEED_W 3
`endif

// File: core/isr_target.v
// I2C register-addressed target: bus engine, register file, data window
// ****************************************************************
// ****************************************************************
`include "isr_defines.vh"
module isr_target #(
	parameter MAX_DLEN = 16'h0110,
	parameter DEPTH_W = 8,
	parameter [31:0] GUARD_VAL = `ISR_UNSUPPORTED,
	parameter [31:0] TMO_VAL = `ISR_UNSUPPORTED,
	parameter [31:0] FM_KHZ = `ISR_CLK_FM_KHZ,
	parameter [31:0] FMP_KHZ = `ISR_CLK_FMP_KHZ,
	parameter [7:0] FEATURES = 8'h0F
) (
	// Clock and reset
	input wire clk,
	input wire nrst,
	// I2C pins, open drain
	input wire scl_in,
	input wire sda_in,
	output reg sda_out_r,
	output reg sda_oe_r,
	// Command engine side
	output reg cmd_valid_r,
	output reg [7:0] cmd_byte_r,
	output reg cmd_last_r,
	input wire busy,
	input wire rsp_valid,
	input wire [15:0] rsp_len,
	input wire [7:0] rsp_byte,
	output reg rsp_pop_r,
	// Persistent store and reset request
	input wire [6:0] stored_addr,
	input wire [2:0] stored_speed,
	output reg persist_addr_we_r,
	output reg persist_speed_we_r,
	output reg [6:0] persist_addr_r,
	output reg [2:0] persist_speed_r,
	output reg restart_req_r,
	// Visible settings
	output reg [15:0] win_len_r,
	output reg [2:0] speed_r
);
	// ****************************************************************
	// Pin synchronisers and bus event detection
	// ****************************************************************
	reg [1:0] scl_s_r, sda_s_r;
	reg scl_d_r, sda_d_r;
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			scl_s_r <= 2'h3;
			sda_s_r <= 2'h3;
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_s_r <= {scl_s_r[0], scl_in};
			sda_s_r <= {sda_s_r[0], sda_in};
			scl_d_r <= scl_s_r[1];
			sda_d_r <= sda_s_r[1];
		end
	end
	wire scl = scl_s_r[1];
	wire sda = sda_s_r[1];
	wire scl_rise = scl & ~scl_d_r;
	wire scl_fall = ~scl & scl_d_r;
	wire start_ev = scl & scl_d_r & sda_d_r & ~sda;
	wire stop_ev = scl & scl_d_r & ~sda_d_r & sda;

	// ****************************************************************
	// Byte engine
	// ****************************************************************
	localparam ST_IDLE = 3'h0;
	localparam ST_ADDR = 3'h1;
	localparam ST_AACK = 3'h2;
	localparam ST_WR = 3'h3;
	localparam ST_WACK = 3'h4;
	localparam ST_RD = 3'h5;
	localparam ST_RACK = 3'h6;
	reg [2:0] st_r;
	reg [7:0] sh_r;
	reg [2:0] bit_r;
	reg [7:0] sel_r;
	reg [1:0] idx_r;
	reg [DEPTH_W-1:0] widx_r;
	reg first_r;
	reg armed_r;
	reg [6:0] addr_r;
	reg [6:0] addr_pend_r;
	reg [15:0] len_pend_r;
	reg [15:0] wbuf_r;
	reg [31:0] rd_word;
	reg [7:0] rd_byte;
	wire [15:0] frame_size = win_len_r - `ISR_FRAME_OVH;
	always @* begin
		case (sel_r)
		`ISR_REG_STATE: rd_word = {busy, rsp_valid, 2'h0, FEATURES[3:0],
			FEATURES[7:4] & 4'h8, 4'h0, rsp_len};
		`ISR_REG_DLEN: rd_word = {win_len_r, 16'h0000};
		`ISR_REG_MAXCLK: rd_word = (speed_r == `ISR_SPEED_FMP) ?
			FMP_KHZ : FM_KHZ;
		`ISR_REG_GUARD: rd_word = GUARD_VAL;
		`ISR_REG_TMO: rd_word = TMO_VAL;
		`ISR_REG_SPEED: rd_word = {13'h0000, speed_r, 16'h0000};
		default: rd_word = 32'h0000_0000;
		endcase
		// Multi-byte registers are sent most significant byte first
		case (idx_r)
		2'h0: rd_byte = rd_word[31:24];
		2'h1: rd_byte = rd_word[23:16];
		2'h2: rd_byte = rd_word[15:8];
		default: rd_byte = rd_word[7:0];
		endcase
		if (sel_r == `ISR_REG_DATA)
			rd_byte = rsp_byte;
	end

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_r <= ST_IDLE;
			sh_r <= 8'h00;
			bit_r <= 3'h0;
			sel_r <= 8'h00;
			idx_r <= 2'h0;
			widx_r <= {DEPTH_W{1'b0}};
			first_r <= 1'b0;
			armed_r <= 1'b0;
			addr_r <= `ISR_ADDR_RESET;
			addr_pend_r <= `ISR_ADDR_RESET;
			len_pend_r <= MAX_DLEN;
			win_len_r <= MAX_DLEN;
			speed_r <= `ISR_SPEED_RESET;
			wbuf_r <= 16'h0000;
			sda_out_r <= 1'b0;
			sda_oe_r <= 1'b0;
			cmd_valid_r <= 1'b0;
			cmd_byte_r <= 8'h00;
			cmd_last_r <= 1'b0;
			rsp_pop_r <= 1'b0;
			persist_addr_we_r <= 1'b0;
			persist_speed_we_r <= 1'b0;
			persist_addr_r <= `ISR_ADDR_RESET;
			persist_speed_r <= `ISR_SPEED_RESET;
			restart_req_r <= 1'b0;
		end else begin
			cmd_valid_r <= 1'b0;
			cmd_last_r <= 1'b0;
			rsp_pop_r <= 1'b0;
			persist_addr_we_r <= 1'b0;
			persist_speed_we_r <= 1'b0;
			if (start_ev | stop_ev) begin
				// Staged settings apply only between accesses
				addr_r <= addr_pend_r;
				win_len_r <= len_pend_r;
				sda_oe_r <= 1'b0;
				bit_r <= 3'h0;
				armed_r <= 1'b0;
				st_r <= stop_ev ? ST_IDLE : ST_ADDR;
				if (stop_ev && st_r == ST_WR && sel_r == `ISR_REG_DATA
					&& !first_r)
					cmd_last_r <= 1'b1;
			end else begin
				case (st_r)
				ST_ADDR: begin
					// The SCL fall that ends a START carries no bit
					if (scl_rise) begin
						sh_r <= {sh_r[6:0], sda};
						bit_r <= bit_r + 3'h1;
						armed_r <= 1'b1;
					end else if (scl_fall && bit_r == 3'h0 && armed_r) begin
						if (sh_r[7:1] == addr_r) begin
							sda_out_r <= 1'b0;
							sda_oe_r <= 1'b1;
							st_r <= ST_AACK;
							idx_r <= 2'h0;
							widx_r <= {DEPTH_W{1'b0}};
							first_r <= ~sh_r[0];
							if (sh_r[0])
								idx_r <= 2'h0;
						end else begin
							st_r <= ST_IDLE;
						end
					end
				end
				ST_AACK: begin
					if (scl_fall) begin
						if (sh_r[0]) begin
							st_r <= ST_RD;
							sda_out_r <= rd_byte[7];
							sda_oe_r <= ~rd_byte[7];
							sh_r <= {rd_byte[6:0], 1'b1};
							if (sel_r == `ISR_REG_DATA)
								rsp_pop_r <= 1'b1;
						end else begin
							st_r <= ST_WR;
							sda_oe_r <= 1'b0;
						end
					end
				end
				ST_WR: begin
					if (scl_rise) begin
						sh_r <= {sh_r[6:0], sda};
						bit_r <= bit_r + 3'h1;
					end else if (scl_fall && bit_r == 3'h0) begin
						sda_out_r <= 1'b0;
						sda_oe_r <= 1'b1;
						st_r <= ST_WACK;
						first_r <= 1'b0;
						if (first_r) begin
							sel_r <= sh_r;
							idx_r <= 2'h0;
						end else begin
							idx_r <= idx_r + 2'h1;
							wbuf_r <= {wbuf_r[7:0], sh_r};
							case (sel_r)
							`ISR_REG_DATA: begin
								// Bytes beyond the window are not forwarded while win_len_r is below 2**DEPTH_W; longer windows forward every byte
								if (widx_r < win_len_r[DEPTH_W-1:0] ||
									win_len_r[15:DEPTH_W] != 0) begin
									cmd_valid_r <= 1'b1;
									cmd_byte_r <= sh_r;
									widx_r <= widx_r + 1'b1;
								end
							end
							`ISR_REG_DLEN: if (idx_r == 2'h1) begin
								if ({wbuf_r[7:0], sh_r} < `ISR_DLEN_MIN)
									len_pend_r <= `ISR_DLEN_MIN;
								else if ({wbuf_r[7:0], sh_r} > MAX_DLEN)
									len_pend_r <= MAX_DLEN;
								else
									len_pend_r <= {wbuf_r[7:0], sh_r};
							end
							`ISR_REG_ADDR: if (idx_r == 2'h1) begin
								addr_pend_r <= sh_r[6:0];
								if (wbuf_r[7]) begin
									persist_addr_we_r <= 1'b1;
									persist_addr_r <= sh_r[6:0];
								end
							end
							`ISR_REG_RESTART: restart_req_r <= 1'b1;
							`ISR_REG_SPEED: if (idx_r == 2'h1) begin
								if (sh_r[2:0] >= `ISR_SPEED_SM &&
									sh_r[2:0] <= `ISR_SPEED_FMP) begin
									speed_r <= sh_r[2:0];
									if (wbuf_r[7]) begin
										persist_speed_we_r <= 1'b1;
										persist_speed_r <= sh_r[2:0];
									end
								end
							end
							default: ;
							endcase
						end
					end
				end
				ST_WACK: if (scl_fall) begin
					sda_oe_r <= 1'b0;
					st_r <= ST_WR;
				end
				ST_RD: begin
					if (scl_fall) begin
						bit_r <= bit_r + 3'h1;
						if (bit_r == 3'h7) begin
							sda_oe_r <= 1'b0;
							st_r <= ST_RACK;
						end else begin
							sda_out_r <= sh_r[7];
							sda_oe_r <= ~sh_r[7];
							sh_r <= {sh_r[6:0], 1'b1};
						end
					end
				end
				ST_RACK: begin
					if (scl_rise) begin
						bit_r <= 3'h0;
						if (sda)
							st_r <= ST_IDLE;
						else
							idx_r <= idx_r + 2'h1;
					end else if (scl_fall) begin
						st_r <= ST_RD;
						sda_out_r <= rd_byte[7];
						sda_oe_r <= ~rd_byte[7];
						sh_r <= {rd_byte[6:0], 1'b1};
						if (sel_r == `ISR_REG_DATA)
							rsp_pop_r <= 1'b1;
					end
				end
				default: st_r <= ST_IDLE;
				endcase
			end
		end
	end
	wire unused_ok = &{1'b0, frame_size, stored_addr, stored_speed};
endmodule // isr_target

// File: test/isr_target_assertions.sv
// Port checker of the I2C register target
// ****
// Checker
// ****
module isr_target_checker #(
	parameter MAX_DLEN = 16'h0110
) (
	// Clock and reset
	input wire clk,
	input wire nrst,
	// Observed outputs
	input wire sda_out_r,
	input wire sda_oe_r,
	input wire cmd_last_r,
	input wire rsp_pop_r,
	input wire persist_addr_we_r,
	input wire persist_speed_we_r,
	input wire [2:0] persist_speed_r,
	input wire restart_req_r,
	input wire [15:0] win_len_r,
	input wire [2:0] speed_r
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	property p_drive_low;
		sda_oe_r |-> !sda_out_r;
	endproperty
	a_drive_low: assert property (p_drive_low)
		else $error("sda driven high");
	property p_mode_code;
		speed_r inside {3'h1, 3'h2, 3'h3, 3'h4};
	endproperty
	a_mode_code: assert property (p_mode_code)
		else $error("bad mode");
	property p_len_range;
		win_len_r >= 16'h0010 && win_len_r <= MAX_DLEN;
	endproperty
	a_len_range: assert property (p_len_range)
		else $error("bad length");
	property p_restart_sticky;
		restart_req_r |=> restart_req_r;
	endproperty
	a_restart_sticky: assert property (p_restart_sticky)
		else $error("restart lost");
	property p_addr_pulse;
		persist_addr_we_r |=> !persist_addr_we_r;
	endproperty
	a_addr_pulse: assert property (p_addr_pulse)
		else $error("addr store long");
	property p_speed_store;
		persist_speed_we_r |->
			persist_speed_r inside {3'h1, 3'h2, 3'h3, 3'h4};
	endproperty
	a_speed_store: assert property (p_speed_store)
		else $error("bad stored mode");
	property p_last_pulse;
		cmd_last_r |=> !cmd_last_r;
	endproperty
	a_last_pulse: assert property (p_last_pulse)
		else $error("last long");
	property p_pop_pulse;
		rsp_pop_r |=> !rsp_pop_r;
	endproperty
	a_pop_pulse: assert property (p_pop_pulse)
		else $error("pop long");
	property p_reset_vals;
		$rose(nrst) |->
			speed_r == 3'h3 && win_len_r == MAX_DLEN && !sda_oe_r;
	endproperty
	a_reset_vals: assert property (p_reset_vals)
		else $error("reset values");
endmodule // isr_target_checker
bind isr_target isr_target_checker #(.MAX_DLEN(MAX_DLEN)) u_chk (.clk, .nrst,
	.sda_out_r, .sda_oe_r, .cmd_last_r, .rsp_pop_r, .persist_addr_we_r,
	.persist_speed_we_r, .persist_speed_r, .restart_req_r, .win_len_r,
	.speed_r);

// File: test/isr_master.sv
// Bus master model driving SCL and open-drain SDA
// ****
// Master
// ****
module isr_master (
	input wire clk,
	input wire sda_oe_r,
	output logic scl,
	output wire sda
);
	timeunit 1ns;
	timeprecision 1ps;
	logic mlow = 1'b0;
	initial scl = 1'b1;
	// Pull-up: line is high unless someone pulls it low
	assign sda = ~(sda_oe_r | mlow);
	task hw;
		repeat (10) @(posedge clk);
	endtask
	// Works from idle and as repeated start
	task start;
		mlow <= 1'b0; hw; scl <= 1'b1; hw; mlow <= 1'b1; hw; scl <= 1'b0; hw;
	endtask
	task stop;
		mlow <= 1'b1; hw; scl <= 1'b1; hw; mlow <= 1'b0; hw;
	endtask
	// Data moves only while SCL is low, sampled at the end of the high phase
	task xb(input logic b, output logic r);
		mlow <= !b; hw; scl <= 1'b1; hw; r = sda; scl <= 1'b0; hw;
	endtask
	task wb(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) xb(d[i], r);
		xb(1'b1, r);
		ack = !r;
	endtask
	task rb(output logic [7:0] d, input logic last);
		logic r;
		for (int i = 7; i >= 0; i--) xb(1'b1, d[i]);
		xb(last, r);
	endtask
endmodule // isr_master

// File: test/isr_target_tb_top.sv
// Self-checking testbench of the I2C register target
// ****
// Bench
// ****
module isr_target_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, nrst = 1'b0, busy = 1'b0, rsp_valid = 1'b0, ack;
	logic [15:0] rsp_len = 16'h0000;
	logic [7:0] rsp_byte = 8'h00, b;
	logic [6:0] ta = 7'h30;
	logic [31:0] v;
	wire scl, sda, oe, cmdv, rstq;
	wire [15:0] wlen;
	wire [2:0] spd;
	wire sdo, cmdl, pop, pawe, pswe;
	wire [7:0] cmdb;
	wire [6:0] paddr;
	wire [2:0] pspd;
	logic [7:0] cbyte = 8'h00;
	logic [6:0] pa_seen = 7'h00;
	logic [2:0] ps_seen = 3'h0;
	int nlast = 0;
	int npop = 0;
	int miscompares = 0, tests_run = 0, cyc = 0, ncmd = 0;
	always #4 clk = ~clk;
	isr_target uut (.clk, .nrst, .scl_in(scl), .sda_in(sda),
		.sda_out_r(sdo), .sda_oe_r(oe), .cmd_valid_r(cmdv),
		.cmd_byte_r(cmdb), .cmd_last_r(cmdl),
		.busy, .rsp_valid, .rsp_len, .rsp_byte, .rsp_pop_r(pop),
		.stored_addr(7'h30), .stored_speed(3'h3),
		.persist_addr_we_r(pawe), .persist_speed_we_r(pswe),
		.persist_addr_r(paddr), .persist_speed_r(pspd),
		.restart_req_r(rstq), .win_len_r(wlen), .speed_r(spd));
	isr_master mst (.clk, .sda_oe_r(oe), .scl, .sda);
	task complete_run;
		if (miscompares == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Cycle ceiling well above the roughly 26k cycles the run needs
	always @(posedge clk) begin
		cyc++;
		if (cmdv === 1'b1) begin
			ncmd++;
			cbyte = cmdb;
		end
		if (cmdl === 1'b1)
			nlast++;
		if (pop === 1'b1)
			npop++;
		if (pawe === 1'b1)
			pa_seen = paddr;
		if (pswe === 1'b1)
			ps_seen = pspd;
		if (cyc == 90000) begin
			miscompares++;
			complete_run;
		end
	end
	task chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task wr(input logic [7:0] s, input logic [15:0] d);
		mst.start; mst.wb({ta, 1'b0}, ack); mst.wb(s, ack);
		mst.wb(d[15:8], ack); mst.wb(d[7:0], ack); mst.stop;
	endtask
	task rd(input logic [7:0] s, input int n);
		v = 32'h0;
		mst.start; mst.wb({ta, 1'b0}, ack); mst.wb(s, ack);
		mst.start; mst.wb({ta, 1'b1}, ack);
		for (int i = 0; i < n; i++) begin
			mst.rb(b, i == n - 1);
			v = {v[23:0], b};
		end
		mst.stop;
	endtask
	task probe(input logic [6:0] a);
		mst.start; mst.wb({a, 1'b0}, ack); mst.stop;
	endtask
	task t_reset;
		chk(spd, 3'h3);
		chk(wlen, 16'h0110);
		chk(rstq, 1'b0);
	endtask
	task t_speed;
		wr(8'h89, 16'h0004); chk(spd, 3'h4);
		rd(8'h84, 4); chk(v, 32'h0000_03E8);
		wr(8'h89, 16'h0007); chk(spd, 3'h4);
		wr(8'h89, 16'h8002);
		chk(ps_seen, 3'h2);
		rd(8'h89, 2); chk(v, 32'h0002);
		rd(8'h84, 4); chk(v, 32'h0000_0190);
	endtask
	task t_len;
		wr(8'h81, 16'h0008); rd(8'h81, 2); chk(v, 32'h0010);
		wr(8'h81, 16'hFFFF); rd(8'h81, 2); chk(v, 32'h0110);
		chk(wlen, 16'h0110);
	endtask
	task t_state;
		busy <= 1'b1; rsp_valid <= 1'b1; rsp_len <= 16'h0123;
		rd(8'h82, 4); chk({v[31:30], v[15:0]}, {2'b11, 16'h0123});
		chk(v[27], 1'b1);
		rd(8'h85, 4); chk(v, 32'h0FFF_FFFF);
		rd(8'h86, 4); chk(v, 32'h0FFF_FFFF);
	endtask
	task t_data;
		ncmd = 0;
		nlast = 0;
		npop = 0;
		rsp_byte <= 8'hC3;
		wr(8'h80, 16'hA55A); chk(ncmd, 2);
		chk(cbyte, 8'h5A);
		chk(nlast, 1);
		rd(8'h80, 2);
		chk(v, 32'h0000_C3C3);
		chk(npop, 2);
	endtask
	task t_addr;
		probe(7'h30); chk(ack, 1'b1);
		wr(8'h83, 16'h8042);
		chk(pa_seen, 7'h42);
		ta = 7'h42;
		probe(7'h42); chk(ack, 1'b1);
		probe(7'h30); chk(ack, 1'b0);
		wr(8'h88, 16'h0000); chk(rstq, 1'b1);
	endtask
	initial begin
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset; t_speed; t_len; t_state; t_data; t_addr;
		complete_run;
	end
endmodule // isr_target_tb_top
